// [ifs_pkg.sv]
// Package for the second interrupt flag status bank.
// Assumes a 32-bit classic Wishbone register bus on one 40 MHz clock.
package ifs_pkg;
    // Register byte offsets (word aligned)
    localparam logic [3:0] IFS_FLAG_OFF = 4'h0;
    localparam logic [3:0] IFS_MASK_OFF = 4'h4;
    localparam logic [3:0] IFS_EVT_OFF = 4'h8;
    // Flag bit positions
    localparam int IFS_PMP_BIT = 13;
    localparam int IFS_OC5_BIT = 9;
    localparam int IFS_IC5_BIT = 7;
    localparam int IFS_IC4_BIT = 6;
    localparam int IFS_IC3_BIT = 5;
    localparam int IFS_SP2E_BIT = 1;
    localparam int IFS_SP2F_BIT = 0;
    localparam int IFS_NSRC = 7;
    // Implemented bits of the 16-bit flag register
    localparam logic [15:0] IFS_IMPL_MASK = 16'h22e3;
    // Values after reset
    localparam logic [15:0] IFS_FLAG_RST = 16'h0000;
    localparam logic [15:0] IFS_MASK_RST = 16'h0000;
    localparam logic [15:0] IFS_EVT_RST = 16'h0000;
endpackage

// [ifs_flag_bit.sv]
// One sticky request flag with software write port.
// Assumes set, write and read-clear strobes are on the same clock.
`timescale 1ns/1ps
module ifs_flag_bit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wr_val_i,
    input wire logic rd_clr_i,
    output logic flag_o
);
    logic flag_reg;
    logic flag_next;
    // A hardware set wins over any clear in the same cycle
    assign flag_next = set_i ? 1'b1 :
                       wr_i ? wr_val_i :
                       rd_clr_i ? 1'b0 : flag_reg;
    assign flag_o = flag_reg;

    // Flag storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule // ifs_flag_bit

// [ifs_bank.sv]
// Second interrupt flag status bank with Wishbone slave and interrupt.
// Assumes event pulses are synchronous to clk_i; bus is classic Wishbone.
//
// Behaviour
// RL1 - Flags read one when pending, zero otherwise; read/write; reset clears.
// RL2 - Bit 9 holds the output compare channel 5 request flag.
// RL3 - Bits 7 and 6 hold input capture 5 and 4 request flags.
// RL4 - Bit 5 holds the input capture channel 3 request flag.
// RL5 - Bit 1 holds the second serial port transfer event flag.
// RL6 - Bit 0 holds the second serial port fault flag.
// RL7 - Bit 13 holds parallel port flag; other bits read zero, ignore writes.
`timescale 1ns/1ps
module ifs_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic parallel_port_evt_i,
    input wire logic compare5_evt_i,
    input wire logic capture5_evt_i,
    input wire logic capture4_evt_i,
    input wire logic capture3_evt_i,
    input wire logic serial2_event_evt_i,
    input wire logic serial2_fault_evt_i,
    output logic irq_o
);
    import ifs_pkg::*;

    logic ack_reg;
    logic err_reg;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic [15:0] mask_reg;
    logic [15:0] evt_reg;
    logic [15:0] evt_next;
    logic [15:0] flags;
    logic [15:0] evt_in;
    logic [15:0] flag_wr_val;
    logic [15:0] evt_rd_clr;

    // Bus decode: one answer per access, ack dropped the cycle after
    wire req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    wire hit_flag = (wb_adr_i == IFS_FLAG_OFF);
    wire hit_mask = (wb_adr_i == IFS_MASK_OFF);
    wire hit_evt = (wb_adr_i == IFS_EVT_OFF);
    wire hit_any = hit_flag || hit_mask || hit_evt;
    wire wr_lo = req && wb_we_i && wb_sel_i[0];
    wire wr_hi = req && wb_we_i && wb_sel_i[1];
    wire flag_wr = (wr_lo || wr_hi) && hit_flag;
    wire evt_rd = req && !wb_we_i && hit_evt;

    // Byte lanes not selected keep the old flag value
    assign flag_wr_val = {wr_hi ? wb_dat_i[15:8] : flags[15:8],
                          wr_lo ? wb_dat_i[7:0] : flags[7:0]};

    // Source events placed at their flag positions
    always_comb begin
        evt_in = 16'h0000;
        evt_in[IFS_PMP_BIT] = parallel_port_evt_i; // RL7
        evt_in[IFS_OC5_BIT] = compare5_evt_i; // RL2
        evt_in[IFS_IC5_BIT] = capture5_evt_i; // RL3
        evt_in[IFS_IC4_BIT] = capture4_evt_i; // RL3
        evt_in[IFS_IC3_BIT] = capture3_evt_i; // RL4
        evt_in[IFS_SP2E_BIT] = serial2_event_evt_i; // RL5
        evt_in[IFS_SP2F_BIT] = serial2_fault_evt_i; // RL6
    end

    // One flag cell per bit; unimplemented bits are tied to zero
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (IFS_IMPL_MASK[gi]) begin : g_impl
                ifs_flag_bit u_bit (
                    .clk_i(clk_i),
                    .rst_i(rst_i),
                    .set_i(evt_in[gi]),
                    .wr_i(flag_wr),
                    .wr_val_i(flag_wr_val[gi]),
                    .rd_clr_i(1'b0),
                    .flag_o(flags[gi])
                ); // RL1
            end else begin : g_unimpl
                assign flags[gi] = 1'b0; // RL7
            end
        end
    endgenerate

    // Event status: sticky copies, cleared by a read, set wins
    assign evt_rd_clr = evt_rd ? 16'hffff : 16'h0000;
    assign evt_next = ((evt_reg & ~evt_rd_clr) | evt_in) & IFS_IMPL_MASK;

    // Read data chosen combinationally, registered with the ack
    assign dat_next = hit_flag ? {16'h0000, flags} :
                      hit_mask ? {16'h0000, mask_reg} :
                      hit_evt ? {16'h0000, evt_reg} : 32'h0000_0000;

    // Interrupt is a level: any unmasked sticky event
    assign irq_o = |(evt_reg & mask_reg);
    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = dat_reg;

    // Bus answer, one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && hit_any;
            err_reg <= req && !hit_any; // Unmapped address gets an error
            dat_reg <= (req && !wb_we_i) ? dat_next : 32'h0000_0000;
        end
    end

    // Mask and event status storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= IFS_MASK_RST;
            evt_reg <= IFS_EVT_RST;
        end else begin
            evt_reg <= evt_next;
            if (req && wb_we_i && hit_mask) begin
                mask_reg <= {wr_hi ? wb_dat_i[15:8] : mask_reg[15:8],
                             wr_lo ? wb_dat_i[7:0] : mask_reg[7:0]}
                            & IFS_IMPL_MASK;
            end
        end
    end

    // Assertions: each source event sets its own flag on the next edge
    sequence s_oc5_event;
        compare5_evt_i;
    endsequence

    a_oc5_sets_flag: assert property ( // RL2
        @(posedge clk_i) disable iff (rst_i)
        s_oc5_event |=> flags[IFS_OC5_BIT])
        else $error("compare5 event did not set bit 9");
    a_ic5_sets_flag: assert property ( // RL3
        @(posedge clk_i) disable iff (rst_i)
        capture5_evt_i |=> flags[IFS_IC5_BIT])
        else $error("capture5 event did not set bit 7");
    a_ic4_sets_flag: assert property ( // RL3
        @(posedge clk_i) disable iff (rst_i)
        capture4_evt_i |=> flags[IFS_IC4_BIT])
        else $error("capture4 event did not set bit 6");
    a_ic3_sets_flag: assert property ( // RL4
        @(posedge clk_i) disable iff (rst_i)
        capture3_evt_i |=> flags[IFS_IC3_BIT])
        else $error("capture3 event did not set bit 5");
    a_sp2e_sets_flag: assert property ( // RL5
        @(posedge clk_i) disable iff (rst_i)
        serial2_event_evt_i |=> flags[IFS_SP2E_BIT])
        else $error("serial2 event did not set bit 1");
    a_sp2f_sets_flag: assert property ( // RL6
        @(posedge clk_i) disable iff (rst_i)
        serial2_fault_evt_i |=> flags[IFS_SP2F_BIT])
        else $error("serial2 fault did not set bit 0");
    a_pmp_sets_flag: assert property ( // RL7
        @(posedge clk_i) disable iff (rst_i)
        parallel_port_evt_i |=> flags[IFS_PMP_BIT])
        else $error("parallel port event did not set bit 13");

    // Spare bit positions never hold a one, in any of the three words
    a_unimpl_zero: assert property ( // RL7
        @(posedge clk_i) disable iff (rst_i)
        (flags & ~IFS_IMPL_MASK) == 16'h0000)
        else $error("unimplemented flag bit is set");
    a_mask_unimpl: assert property ( // RL7
        @(posedge clk_i) disable iff (rst_i)
        (mask_reg & ~IFS_IMPL_MASK) == 16'h0000)
        else $error("unimplemented mask bit is set");
    a_evt_unimpl: assert property ( // RL7
        @(posedge clk_i) disable iff (rst_i)
        (evt_reg & ~IFS_IMPL_MASK) == 16'h0000)
        else $error("unimplemented event bit is set");

    // Software writes of the flag word, whole and per byte lane
    a_flag_write: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (flag_wr && evt_in == 16'h0000) |=>
            flags == ($past(flag_wr_val) & IFS_IMPL_MASK))
        else $error("flag write not stored");
    a_flag_holds: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (!flag_wr && evt_in == 16'h0000) |=> $stable(flags))
        else $error("flag changed without cause");
    a_low_lane_keeps: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (flag_wr && wb_sel_i[1:0] == 2'b01 && evt_in == 16'h0000) |=>
            (flags[15:8] == $past(flags[15:8])))
        else $error("low lane write touched the high byte");
    a_high_lane_keeps: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (flag_wr && wb_sel_i[1:0] == 2'b10 && evt_in == 16'h0000) |=>
            (flags[7:0] == $past(flags[7:0])))
        else $error("high lane write touched the low byte");

    // Reads return the word that stood at the taking edge
    a_read_value: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_flag && !flag_wr) |=>
            (wb_ack_o && wb_dat_o == {16'h0000, $past(flags)}))
        else $error("flag read returned wrong data");
    a_read_mask: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_mask) |=>
            (wb_dat_o == {16'h0000, $past(mask_reg)}))
        else $error("mask read returned wrong data");
    a_read_evt: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_evt) |=>
            (wb_dat_o == {16'h0000, $past(evt_reg)}))
        else $error("event status read returned wrong data");

    // Every register leaves reset cleared, with the bus and irq quiet
    a_reset_values: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (flags == IFS_FLAG_RST
            && mask_reg == IFS_MASK_RST && evt_reg == IFS_EVT_RST
            && !wb_ack_o && !wb_err_o && !irq_o))
        else $error("register not cleared by reset");

    // Bus answer: exactly one ack or err for each taken request
    sequence s_req_mapped;
        req && hit_any;
    endsequence

    sequence s_req_unmapped;
        req && !hit_any;
    endsequence

    sequence s_one_ack;
        (wb_ack_o && !wb_err_o) ##1 !wb_ack_o;
    endsequence

    sequence s_one_err;
        (wb_err_o && !wb_ack_o) ##1 !wb_err_o;
    endsequence

    a_ack_after_req: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        s_req_mapped |=> s_one_ack)
        else $error("mapped access not acknowledged exactly once");
    a_err_after_req: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        s_req_unmapped |=> s_one_err)
        else $error("unmapped access not refused exactly once");
    a_no_stray_ack: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        !req |=> (!wb_ack_o && !wb_err_o))
        else $error("answer given without a request");

    // Read data stands for one answer cycle only; otherwise it is zero
    a_dat_idle_zero: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data not zero outside an answer");
    a_write_no_data: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (req && wb_we_i) |=> (wb_dat_o == 32'h0000_0000))
        else $error("write answer carries data");
    a_upper_half_zero: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");

    // A refused access must not disturb the mask; mask writes land
    a_err_no_effect: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        s_req_unmapped |=> $stable(mask_reg))
        else $error("refused access changed the mask");
    a_mask_write: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (req && wb_we_i && hit_mask && wb_sel_i[1:0] == 2'b11) |=>
            (mask_reg == ($past(wb_dat_i[15:0]) & IFS_IMPL_MASK)))
        else $error("mask write not stored");

    // Sticky event status: set by events, kept until read, then cleared
    a_evt_sticky: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        !evt_rd |=>
            ((evt_reg & $past(evt_reg)) == $past(evt_reg)))
        else $error("event status bit lost without a read");
    a_evt_read_clear: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (evt_rd && evt_in == 16'h0000) |=> (evt_reg == 16'h0000))
        else $error("event status not cleared by its read");
    a_evt_sets: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (evt_in != 16'h0000) |=>
            ((evt_reg & $past(evt_in)) == $past(evt_in)))
        else $error("event did not set its status bit");

    // The interrupt level follows the unmasked sticky events
    a_irq_on_event: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        ((|(evt_in & mask_reg)) && !(req && wb_we_i && hit_mask)) |=>
            irq_o)
        else $error("unmasked event did not raise the interrupt");
    a_irq_clear: assert property ( // RL1
        @(posedge clk_i) disable iff (rst_i)
        (evt_rd && evt_in == 16'h0000) |=> !irq_o)
        else $error("interrupt stayed high after status read");
endmodule // ifs_bank

// [ifs_evt_src.sv]
// Event source model standing for the peripherals beside the flag bank.
// Assumes one request at a time from the bench, on the bank's clock.
`timescale 1ns/1ps
module ifs_evt_src (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [2:0] sel_i,
    output logic [6:0] evt_o
);
    // One-cycle pulse on the chosen line, so a flag is set exactly once
    always_ff @(posedge clk_i) begin
        evt_o <= go_i ? 7'(7'h01 << sel_i) : 7'h00;
    end
endmodule // ifs_evt_src

// [ifs_bank_bench.sv]
// Self-checking bench for the second interrupt flag status bank.
// Assumes the event model pulses one source at a time on clk_i.
`timescale 1ns/1ps
module ifs_bank_bench;
    import ifs_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, ack, err, irq;
    logic [3:0] adr = 4'h0, sel = 4'hf, bsel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, rnd = 32'h2da3;
    logic [2:0] src = 3'h0;
    logic [6:0] evt;
    logic [31:0] expq[$];
    int error_cnt = 0, compares = 0;
    int bitpos[7] = '{13, 9, 7, 6, 5, 1, 0};
    ifs_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .parallel_port_evt_i(evt[0]), .compare5_evt_i(evt[1]),
        .capture5_evt_i(evt[2]), .capture4_evt_i(evt[3]),
        .capture3_evt_i(evt[4]), .serial2_event_evt_i(evt[5]),
        .serial2_fault_evt_i(evt[6]), .irq_o(irq));
    ifs_evt_src src_m (.clk_i(clk_i), .go_i(go), .sel_i(src), .evt_o(evt));
    // 40 MHz clock
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One classic cycle, held until ack or err; only the watchdog ends a hang
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
        input logic e_err);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= bsel;
        wdat <= {16'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && err !== 1'b1) begin
            @(posedge clk_i);
        end
        chk("err", {31'h0, e_err}, {31'h0, err});
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 16'h0, 1'b0);
    endtask
    task automatic pulse(input int i);
        src <= 3'(i);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // Monitor: each read answer is matched with the oldest expected note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0)
            chk("rdata", expq.size() > 0 ? expq.pop_front() : 32'hx, rdat);
    end
    // Watchdog far beyond the fewer than two hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IFS_FLAG_OFF, 32'h0);
        rd(IFS_MASK_OFF, 32'h0);
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            rd(IFS_FLAG_OFF, 32'h1 << bitpos[i]);
            rd(IFS_EVT_OFF, 32'h1 << bitpos[i]);
            chk("irq_masked", 32'h0, {31'h0, irq});
            wb(1'b1, IFS_FLAG_OFF, 16'h0000, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wb(1'b1, IFS_FLAG_OFF, rnd[15:0], 1'b0);
            rd(IFS_FLAG_OFF, {16'h0, rnd[15:0] & IFS_IMPL_MASK});
        end
        // Byte lanes: an unselected lane keeps its old flags
        bsel = 4'h1;
        wb(1'b1, IFS_FLAG_OFF, 16'hffff, 1'b0);
        rd(IFS_FLAG_OFF, {16'h0, {rnd[15:8], 8'hff} & IFS_IMPL_MASK});
        bsel = 4'h2;
        wb(1'b1, IFS_FLAG_OFF, 16'h0000, 1'b0);
        rd(IFS_FLAG_OFF, {16'h0, 16'h00ff & IFS_IMPL_MASK});
        bsel = 4'hf;
        wb(1'b1, IFS_MASK_OFF, 16'hffff, 1'b0);
        rd(IFS_MASK_OFF, {16'h0, IFS_IMPL_MASK});
        pulse(1);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd(IFS_EVT_OFF, 32'h200);
        chk("irq_off", 32'h0, {31'h0, irq});
        // Mid-run reset with flags and mask set: both must come back clear
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IFS_FLAG_OFF, 32'h0);
        rd(IFS_MASK_OFF, 32'h0);
        wb(1'b0, 4'hc, 16'h0, 1'b1);
        report_and_stop;
    end
endmodule // ifs_bank_bench
